// ### logic/art_consts.vh
/*
 * Constants of the second relock timer block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 20 MHz system clock and byte addresses on a 4-bit bus.
 */
`ifndef ART_CONSTS_VH
`define ART_CONSTS_VH

`define ART_CLK_KHZ 20000
`define ART_HAZ_HALF_MS 500
`define ART_HAZ_HALF_CYC (`ART_HAZ_HALF_MS * `ART_CLK_KHZ)
`define ART_RELOCK_S 30
`define ART_RELOCK_CYC (`ART_RELOCK_S * `ART_CLK_KHZ * 1000)

`define ART_AW 4
`define ART_OFF_CTRL 4'h0
`define ART_OFF_STATE 4'h4
`define ART_OFF_STATUS 4'h8

`define ART_CTRL_SMART 0
`define ART_CTRL_MECH 1
`define ART_CTRL_HORN 2
`define ART_CTRL_INHIBIT 3

`define ART_STAT_HOOD_MEMO 0
`define ART_STAT_TRUNK_MEMO 1
`define ART_STAT_HAZ_BUSY 2
`define ART_STAT_LOCK_PEND 3
`define ART_STAT_PINS_LSB 8

`define ART_NSTATE 6
`define ART_ST_UNARMED 6'h01
`define ART_ST_ALARM 6'h02
`define ART_ST_PREARM 6'h04
`define ART_ST_ARMHOLD 6'h08
`define ART_ST_RELOCK2 6'h10
`define ART_ST_OTHER 6'h20
`define ART_ST_RESET `ART_ST_UNARMED

`define ART_NPIN 12

`endif

// ### logic/art_delay_timer.v
/*
 * Restartable one-shot down counter; pulses expired for one cycle.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module art_delay_timer #(
  parameter [31:0] COUNT = 32'h0000_0010
) (
  input wire clock,
  input wire rstn,
  input wire start,
  input wire stop,
  output reg running,
  output reg expired
);
  reg [31:0] cnt_q;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        // Restart always reloads the full delay
        cnt_q <= COUNT - 32'h0000_0001;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (cnt_q == 32'h0000_0000) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h0000_0001;
        end
      end
    end
  end
endmodule // art_delay_timer
`default_nettype wire

// ### logic/art_hazard_pulser.v
/*
 * Hazard relay driver: two on/off pulses of HALF cycles each phase.
 * Assumes start is a one-cycle pulse; a new start restarts the pattern.
 */
`timescale 1ns/10ps
`default_nettype none
module art_hazard_pulser #(
  parameter [31:0] HALF = 32'h0000_0010
) (
  input wire clock,
  input wire rstn,
  input wire start,
  input wire stop,
  output reg relay,
  output reg busy
);
  reg [31:0] cnt_q;
  reg [1:0] phase_q;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      phase_q <= 2'h0;
      relay <= 1'b0;
      busy <= 1'b0;
    end else if (start) begin
      cnt_q <= HALF - 32'h0000_0001;
      phase_q <= 2'h0;
      relay <= 1'b1;
      busy <= 1'b1;
    end else if (stop) begin
      relay <= 1'b0;
      busy <= 1'b0;
    end else if (busy) begin
      if (cnt_q == 32'h0000_0000) begin
        cnt_q <= HALF - 32'h0000_0001;
        phase_q <= phase_q + 2'h1;
        // Phases: on, off, on, off
        relay <= ~phase_q[0] ? 1'b0 : (phase_q != 2'h3);
        busy <= (phase_q != 2'h3);
      end else begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
    end
  end
endmodule // art_hazard_pulser
`default_nettype wire

// ### logic/art_relock_ctrl.v
/*
 * Anti-theft state holder around the second relock timer state: entry
 * into it on unlock, automatic relock, and exit to pre-arm on a
 * confirmed lock. Registers sit on a plain strobe port.
 * Assumes the other states' own transitions are driven by software
 * through the state register, and that all key, switch and command
 * inputs are asynchronous levels from outside.
 * A lock that is never confirmed leaves the block in the relock
 * state until software writes the state; new lock requests alone do not end it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "art_consts.vh"
module art_relock_ctrl #(
  parameter [31:0] SECOND_RELOCK_DELAY = `ART_RELOCK_CYC,
  parameter [31:0] HAZARD_HALF = `ART_HAZ_HALF_CYC
) (
  input wire clock,
  input wire rstn,
  input wire [`ART_AW-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire tx_unlock,
  input wire tx_lock,
  input wire remote_keyless_command_unlock,
  input wire remote_keyless_command_lock,
  input wire passive_unlock,
  input wire passive_lock,
  input wire mech_lock,
  input wire lock_confirmed,
  input wire door_open,
  input wire hood_open,
  input wire trunk_open,
  input wire ignition_key_removed,
  output wire hazard_relay,
  output reg horn_relay,
  output reg start_inhibit_relay,
  output reg door_lock,
  output reg [`ART_NSTATE-1:0] state_q
);
  localparam [`ART_NSTATE-1:0] ST_UNARMED = `ART_ST_UNARMED;
  localparam [`ART_NSTATE-1:0] ST_ALARM = `ART_ST_ALARM;
  localparam [`ART_NSTATE-1:0] ST_PREARM = `ART_ST_PREARM;
  localparam [`ART_NSTATE-1:0] ST_ARMHOLD = `ART_ST_ARMHOLD;
  localparam [`ART_NSTATE-1:0] ST_RELOCK2 = `ART_ST_RELOCK2;
  localparam [`ART_NSTATE-1:0] ST_OTHER = `ART_ST_OTHER;

  // Pin order in the synchroniser vector
  localparam P_TXU = 0;
  localparam P_TXL = 1;
  localparam P_RKU = 2;
  localparam P_RKL = 3;
  localparam P_PAU = 4;
  localparam P_PAL = 5;
  localparam P_MEC = 6;
  localparam P_CNF = 7;
  localparam P_DOR = 8;
  localparam P_HOD = 9;
  localparam P_TRK = 10;
  localparam P_KEY = 11;

  wire [`ART_NPIN-1:0] pins_raw;
  reg [`ART_NPIN-1:0] sync1_q;
  reg [`ART_NPIN-1:0] sync2_q;
  reg [`ART_NPIN-1:0] prev_q;
  wire [`ART_NPIN-1:0] rise;

  reg smart_key_variant_q;
  reg mech_en_q;
  reg hood_memo_q;
  reg trunk_memo_q;
  reg lock_pend_q;
  reg [`ART_NSTATE-1:0] state_d;

  wire unlock_ev;
  wire lock_req;
  wire enter_relock;
  wire restart;
  wire in_relock;
  wire relock_expired;
  wire haz_busy;
  wire enter_prearm;
  wire sw_state_wr;
  wire ctrl_wr;
  wire hatch_open;

  assign pins_raw = {ignition_key_removed, trunk_open, hood_open, door_open,
    lock_confirmed, mech_lock, passive_lock, passive_unlock,
    remote_keyless_command_lock, remote_keyless_command_unlock,
    tx_lock, tx_unlock};

  // Two flops before use; edges read only from the second stage
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= {`ART_NPIN{1'b0}};
      sync2_q <= {`ART_NPIN{1'b0}};
      prev_q <= {`ART_NPIN{1'b0}};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edges only: a held button counts once
  assign rise = sync2_q & ~prev_q;

  function is_unlock;
    input smart;
    input [`ART_NPIN-1:0] r;
    begin
      if (smart)
        is_unlock = r[P_RKU] | r[P_PAU];
      else
        is_unlock = r[P_TXU];
    end
  endfunction

  function is_lock;
    input smart;
    input mech;
    input [`ART_NPIN-1:0] r;
    begin
      is_lock = (smart ? (r[P_RKL] | r[P_PAL]) : r[P_TXL])
        | (mech & r[P_MEC]);
    end
  endfunction

  // Shared address decode for the write strobes
  function reg_hit;
    input [`ART_AW-1:0] a;
    input [`ART_AW-1:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  // Doors shut while the hood or trunk stands open
  function shut_hatch_open;
    input [`ART_NPIN-1:0] s;
    begin
      shut_hatch_open = ~s[P_DOR] & (s[P_HOD] | s[P_TRK]);
    end
  endfunction

  assign unlock_ev = is_unlock(smart_key_variant_q, rise);
  assign in_relock = (state_q == ST_RELOCK2);
  assign hatch_open = sync2_q[P_HOD] | sync2_q[P_TRK];
  assign sw_state_wr = wr & reg_hit(addr, `ART_OFF_STATE);
  assign ctrl_wr = wr & reg_hit(addr, `ART_OFF_CTRL);

  // Entry conditions from the unarmed, alarm, pre-arm and arm-hold states
  assign enter_relock = unlock_ev & (
    ((state_q == ST_UNARMED) & sync2_q[P_KEY] & hatch_open) |
    ((state_q == ST_ALARM) & shut_hatch_open(sync2_q)) |
    ((state_q == ST_PREARM) & shut_hatch_open(sync2_q)) |
    (state_q == ST_ARMHOLD));

  assign restart = enter_relock | (in_relock & unlock_ev);

  // Lock requests, including the mechanical key when enabled
  assign lock_req = relock_expired |
    is_lock(smart_key_variant_q, mech_en_q, rise);

  // Lock must be requested, now or earlier, while confirmed, before leaving
  assign enter_prearm = in_relock & ~unlock_ev &
    (lock_pend_q | lock_req) & sync2_q[P_CNF];

  // Leaving the relock state drops a pending expiry
  art_delay_timer #(
    .COUNT(SECOND_RELOCK_DELAY)
  ) u_relock_timer (
    .clock(clock),
    .rstn(rstn),
    .start(restart),
    .stop(~in_relock & ~enter_relock),
    .running(),
    .expired(relock_expired)
  );

  // Pattern runs out even if the state is left
  art_hazard_pulser #(
    .HALF(HAZARD_HALF)
  ) u_hazard (
    .clock(clock),
    .rstn(rstn),
    .start(restart),
    .stop(1'b0),
    .relay(hazard_relay),
    .busy(haz_busy)
  );

  always @* begin
    state_d = state_q;
    if (sw_state_wr) begin
      // Software owns the states outside this block's scope
      case (wdata[`ART_NSTATE-1:0])
        ST_UNARMED: state_d = ST_UNARMED;
        ST_ALARM: state_d = ST_ALARM;
        ST_PREARM: state_d = ST_PREARM;
        ST_ARMHOLD: state_d = ST_ARMHOLD;
        ST_RELOCK2: state_d = ST_RELOCK2;
        ST_OTHER: state_d = ST_OTHER;
        default: state_d = state_q;
      endcase
    end else begin
      case (state_q)
        ST_UNARMED, ST_ALARM, ST_PREARM, ST_ARMHOLD: begin
          if (enter_relock)
            state_d = ST_RELOCK2;
        end
        ST_RELOCK2: begin
          if (enter_prearm)
            state_d = ST_PREARM;
        end
        ST_OTHER: state_d = ST_OTHER;
        default: state_d = ST_UNARMED;
      endcase
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= `ART_ST_RESET;
      smart_key_variant_q <= 1'b0;
      mech_en_q <= 1'b0;
      horn_relay <= 1'b0;
      start_inhibit_relay <= 1'b0;
      hood_memo_q <= 1'b0;
      trunk_memo_q <= 1'b0;
      lock_pend_q <= 1'b0;
      door_lock <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ctrl_wr) begin
        smart_key_variant_q <= wdata[`ART_CTRL_SMART];
        mech_en_q <= wdata[`ART_CTRL_MECH];
      end

      // Hardware switch-off beats a same-cycle software switch-on
      if (enter_relock & (state_q == ST_ALARM)) begin
        horn_relay <= 1'b0;
        start_inhibit_relay <= 1'b0;
      end else if (ctrl_wr) begin
        horn_relay <= wdata[`ART_CTRL_HORN];
        start_inhibit_relay <= wdata[`ART_CTRL_INHIBIT];
      end

      // Switch levels as seen on entry
      if (enter_relock) begin
        hood_memo_q <= sync2_q[P_HOD];
        trunk_memo_q <= sync2_q[P_TRK];
      end

      // Automatic door lock on expiry, state kept
      door_lock <= in_relock & relock_expired;

      // An unlock drops a lock still waiting for confirmation
      if (~in_relock | enter_prearm | unlock_ev)
        lock_pend_q <= 1'b0;
      else if (lock_req)
        lock_pend_q <= 1'b1;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `ART_OFF_CTRL: begin
            rdata[`ART_CTRL_SMART] <= smart_key_variant_q;
            rdata[`ART_CTRL_MECH] <= mech_en_q;
            rdata[`ART_CTRL_HORN] <= horn_relay;
            rdata[`ART_CTRL_INHIBIT] <= start_inhibit_relay;
          end
          `ART_OFF_STATE: rdata[`ART_NSTATE-1:0] <= state_q;
          // Status is read-only; writes to it are dropped
          `ART_OFF_STATUS: begin
            rdata[`ART_STAT_HOOD_MEMO] <= hood_memo_q;
            rdata[`ART_STAT_TRUNK_MEMO] <= trunk_memo_q;
            rdata[`ART_STAT_HAZ_BUSY] <= haz_busy;
            rdata[`ART_STAT_LOCK_PEND] <= lock_pend_q;
            rdata[`ART_STAT_PINS_LSB+`ART_NPIN-1:`ART_STAT_PINS_LSB]
              <= sync2_q;
          end
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // art_relock_ctrl
`default_nettype wire

// ### tb/art_relock_ctrl_asserts.sv
/* Port checker for the relock controller.
   Assumes one clock domain and a bind onto art_relock_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module art_relock_chk #(
  parameter [31:0] HAZARD_HALF = 32'h0000_0004
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic lock_confirmed,
  input wire logic hazard_relay,
  input wire logic horn_relay,
  input wire logic start_inhibit_relay,
  input wire logic door_lock,
  input wire logic [5:0] state_q
);
  logic [31:0] hcnt_q;
  wire ent = state_q == 6'h10;
  // Length of each hazard on-phase
  always @(posedge clock or negedge rstn) begin
    if (!rstn) hcnt_q <= 32'h0;
    else hcnt_q <= hazard_relay ? hcnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_HAZ_ON: assert property ($fell(hazard_relay) |-> hcnt_q == HAZARD_HALF)
    else $error("hazard on-phase length wrong");
  AST_LOCK_PULSE: assert property (door_lock |=> !door_lock)
    else $error("door lock pulse too long");
  AST_LOCK_SRC: assert property (door_lock |-> $past(state_q) == 6'h10)
    else $error("door lock outside relock state");
  AST_ENTRY_HAZ: assert property ($rose(ent) && !$past(wr) |-> hazard_relay)
    else $error("entry without hazard pulse");
  AST_ENTRY_FROM: assert property ($rose(ent) && !$past(wr) |-> !$past(state_q[5]))
    else $error("entry from a refused state");
  AST_ALARM_OFF: assert property ($rose(ent) && $past(state_q) == 6'h02
    |-> !horn_relay && !start_inhibit_relay)
    else $error("relays not off after alarm entry");
  AST_PREARM_CONF: assert property (state_q == 6'h04 && $past(state_q) == 6'h10
    && !$past(wr) |-> $past(lock_confirmed, 3))
    else $error("pre-arm without lock confirmation");
  AST_ONEHOT: assert property ($onehot(state_q))
    else $error("state not one-hot");
  cover property ($rose(ent));
  cover property (door_lock);
  cover property ($fell(ent) && state_q == 6'h04);
endmodule // art_relock_chk
bind art_relock_ctrl art_relock_chk #(.HAZARD_HALF(HAZARD_HALF))
  i_art_relock_chk (.clock, .rstn, .wr, .rd, .rdata, .lock_confirmed,
  .hazard_relay, .horn_relay, .start_inhibit_relay, .door_lock, .state_q);
`default_nettype wire

// ### tb/art_lock_model.sv
/* Door lock actuator model: confirms an automatic lock some cycles later.
   Assumes door_lock is a one-cycle request on the system clock. */
`timescale 1ns/10ps
`default_nettype none
module art_lock_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic door_lock,
  input wire logic enable,
  input wire logic hold,
  output logic lock_confirmed
);
  logic [3:0] dly_q;
  // Slow actuator: confirmation lags by 8 cycles, lasts 8
  always @(posedge clock or negedge rstn) begin
    if (!rstn) dly_q <= 4'h0;
    else if (door_lock && enable) dly_q <= 4'h1;
    else if (dly_q != 4'h0) dly_q <= dly_q + 4'h1;
  end
  assign lock_confirmed = hold | dly_q[3];
endmodule // art_lock_model
`default_nettype wire

// ### tb/art_relock_ctrl_tb_top.sv
/* Directed bench of the relock controller with a lock actuator model.
   Assumes short timer parameters so that the run stays brief. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, s); end end
module art_relock_ctrl_tb_top;
  logic clock, rstn, wr, rd, men;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [11:0] p;
  wire [31:0] rdata;
  wire [5:0] st;
  wire conf, haz, horn, inh, dlk;
  int miscompares, total_checks, cyc, n, hon, h;
  int lc [6] = '{0, 1, 1, 2, 0, 0};
  int lp [6] = '{1, 3, 5, 6, 6, 3};
  logic [5:0] le [6] = '{6'h04, 6'h04, 6'h04, 6'h04, 6'h10, 6'h10};
  int uc [4] = '{0, 1, 1, 1};
  int up [4] = '{0, 2, 4, 0};
  logic [5:0] ue [4] = '{6'h10, 6'h10, 6'h10, 6'h08};
  art_relock_ctrl #(.SECOND_RELOCK_DELAY(32'h0000_0028),
    .HAZARD_HALF(32'h0000_0004)) i_art_relock_ctrl (.clock(clock),
    .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_unlock(p[0]), .tx_lock(p[1]),
    .remote_keyless_command_unlock(p[2]),
    .remote_keyless_command_lock(p[3]), .passive_unlock(p[4]),
    .passive_lock(p[5]), .mech_lock(p[6]), .lock_confirmed(conf),
    .door_open(p[8]), .hood_open(p[9]), .trunk_open(p[10]),
    .ignition_key_removed(p[11]), .hazard_relay(haz), .horn_relay(horn),
    .start_inhibit_relay(inh), .door_lock(dlk), .state_q(st));
  art_lock_model i_art_lock_model (.clock(clock), .rstn(rstn),
    .door_lock(dlk), .enable(men), .hold(p[7]), .lock_confirmed(conf));
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock); wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e,
    input string s);
    @(posedge clock); addr <= a; rd <= 1'b1;
    @(posedge clock); rd <= 1'b0;
    @(negedge clock); `CHK(s, e, rdata)
    @(posedge clock);
  endtask
  // Spacing keeps each hazard pattern whole before the next event
  task automatic press(input int i);
    repeat (16) @(posedge clock);
    p[i] <= 1'b1;
    repeat (6) @(posedge clock);
    p[i] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wait_lock();
    n = 0;
    while (dlk !== 1'b1 && n < 100) begin @(negedge clock); n++; end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin clock = 1'b0; forever #25 clock = ~clock; end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin miscompares++; end_sim(); end
  end
  // Hazard on-cycles, compared over one whole pattern
  always @(posedge clock) if (haz === 1'b1) hon++;
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; men = 1'b0;
    addr = 4'h0; wdata = 32'h0; p = 12'h000;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rchk(4'h4, 32'h1, "state reset");
    rchk(4'h0, 32'h0, "ctrl reset");
    wreg(4'hC, 32'hF);
    rchk(4'hC, 32'h0, "unmapped");
    wreg(4'h4, 32'h3);
    rchk(4'h4, 32'h1, "bad state write");
    wreg(4'h4, 32'h20);
    rchk(4'h4, 32'h20, "other state write");
    wreg(4'h4, 32'h1);
    p <= 12'hA00;
    press(2);
    rchk(4'h4, 32'h1, "plain variant ignores remote cmd");
    press(0);
    rchk(4'h8, 32'h000A_0005, "entry status");
    press(0);
    men <= 1'b1;
    wait_lock();
    `CHK("restarted relock delay", 1'b1, n > 25 && n < 45)
    rchk(4'h4, 32'h10, "stays after relock");
    $display("test unlock entry and relock done");
    repeat (14) @(posedge clock);
    rchk(4'h4, 32'h4, "auto lock to pre-arm");
    men <= 1'b0;
    press(0);
    rchk(4'h4, 32'h10, "pre-arm entry");
    for (int i = 0; i < 6; i++) begin
      wreg(4'h0, 32'(lc[i]));
      wreg(4'h4, 32'h10);
      press(lc[i][0] ? 2 : 0);
      p[7] <= 1'b1;
      press(lp[i]);
      rchk(4'h4, {26'h0, le[i]}, "lock source");
      p[7] <= 1'b0;
    end
    $display("test lock sources done");
    for (int i = 0; i < 4; i++) begin
      wreg(4'h0, 32'(uc[i]));
      wreg(4'h4, 32'h8);
      press(up[i]);
      rchk(4'h4, {26'h0, ue[i]}, "arm-hold unlock");
    end
    wreg(4'h4, 32'h2);
    wreg(4'h0, 32'hC);
    @(negedge clock);
    `CHK("relay pins on", 2'b11, {horn, inh})
    h = hon;
    press(0);
    rchk(4'h4, 32'h10, "alarm entry");
    rchk(4'h0, 32'h0, "relays off");
    `CHK("relay pins off", 2'b00, {horn, inh})
    repeat (8) @(posedge clock);
    `CHK("hazard on cycles", 2 * 4, hon - h)
    $display("test arm-hold and alarm done");
    end_sim();
  end
endmodule // art_relock_ctrl_tb_top
`default_nettype wire
